// ---- rtl/pft_regs.vh ----
// Constants for the power stage fault and temperature telemetry block.
// Assumes a 50 MHz core clock and an APB master with 32-bit data.
//
// Overview of operation
// - Minimum-pulse bit set stretches each driven PWM pulse to a minimum width.
// - With no phase fault, the sense voltage becomes the rail's paged temperature reading.
// - Temperature uses a programmable slope and a zero-degree sense-voltage offset.
// - Power-stage undervoltage detection only acts while the paged enable bit or drive-monitor select is set.
// - Overvoltage conditions except open sense turn output off, no retry; UV follows UV response.
// - Power-stage faults are reported in status words, including an output-current bit.
// - Both voltage bits may set; current and ready bits track live stage state.
// - Both remote sense lines are tested at reset; an open line disables outputs.
// - An open-line result stays latched until a retest after reset or full reset.
// - Channel ready bit reads 0 during enabled stage undervoltage, otherwise 1.
// - Drive-monitor select turns the sense pin into a drive-supply undervoltage input.
// - The single drive-supply undervoltage input applies to both channels.
// - With the monitor active, common bit 0 is ignored and channel 1's own UV input is dropped.
// - Temperature reads are answered even when the sense input is unused.
// - Temperature slope resets to 8 mV per degree as a linear-11 word.
// - Zero-degree offset resets to 600 mV as a linear-11 word.
`ifndef PFT_REGS_VH
`define PFT_REGS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define PFT_A_CTRL       8'h00
`define PFT_A_MODE0      8'h10
`define PFT_A_MODE1      8'h14
`define PFT_A_CHAN_CFG   8'h18
`define PFT_A_PHASE_CFG  8'h1c
`define PFT_A_SLOPE0     8'h20
`define PFT_A_SLOPE1     8'h24
`define PFT_A_ZERO0      8'h28
`define PFT_A_ZERO1      8'h2c
`define PFT_A_TEMP0      8'h30
`define PFT_A_TEMP1      8'h34
`define PFT_A_STAT0      8'h38
`define PFT_A_STAT1      8'h3c
`define PFT_A_PADS       8'h40
`define PFT_A_INT_STAT   8'h44
`define PFT_A_INT_MASK   8'h48

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define PFT_MODE_RST      8'h02
`define PFT_CHAN_CFG_RST  8'h1d
`define PFT_PHASE_CFG_RST 8'h03
`define PFT_SLOPE_RST     16'hd200
`define PFT_ZERO_RST      16'h0258
`define PFT_B_UV_EN       0
`define PFT_B_MINPW       1
`define PFT_B_DRVMON      5
`define PFT_B_PHASE0      0
`define PFT_B_FULL_RESET  0
`define PFT_B_VOUT_OV     7
`define PFT_B_VOUT_UV     4
`define PFT_B_IOUT_STAGE  11
`define PFT_B_RDY0        14
`define PFT_B_RDY1        15
`define PFT_INT_W         9
`define PFT_INT_OPEN      8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PFT_CLK_MHZ       50
`define PFT_MINPW_NS      40
`define PFT_MINPW_CYC     ((`PFT_MINPW_NS * `PFT_CLK_MHZ + 999) / 1000)
`define PFT_SENSE_US      10
`define PFT_SENSE_CYC     (`PFT_SENSE_US * `PFT_CLK_MHZ)
`define PFT_UV_RETRY_MS   350
`define PFT_UV_RETRY_CYC  (`PFT_UV_RETRY_MS * 1000 * `PFT_CLK_MHZ)

// ----------------------------------------------------------------------
// Temperature arithmetic
// ----------------------------------------------------------------------
`define PFT_FX_FRAC       8
`define PFT_DIV_STEPS     6'd40
`define PFT_TEMP_EXP      5'b11110
`define PFT_MANT_MAX      11'h3ff

`endif

// ---- rtl/pft_top.v ----
// Power stage fault and temperature telemetry with an APB register file.
// Assumes digitized sense codes in mV and comparator levels synchronous to core_clk.
`timescale 1ns/1ps
`include "pft_regs.vh"

module pft_top #(
   parameter [24:0] UV_RETRY_CYC = `PFT_UV_RETRY_CYC
) (
   // Clock and reset
   input  wire        core_clk,
   input  wire        nrst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   // Temperature/fault sense lines, one per channel
   input  wire [23:0] temp_fault_sense_input,
   input  wire [1:0]  sense_valid,
   input  wire [1:0]  stage_fault,
   input  wire        stage_uv0,
   input  wire        second_temp_fault_sense_input,
   input  wire        drive_supply_uv_input,
   // Output comparators, remote sense test and run requests
   input  wire [1:0]  out_ov,
   input  wire [1:0]  out_uv,
   input  wire [1:0]  remote_sense_positive_open,
   input  wire [1:0]  run_req,
   input  wire [1:0]  pwm_in,
   // Outputs to power stages and system
   output reg  [1:0]  pwm_out,
   output reg  [1:0]  out_enable,
   output reg         phase_pair_mode,
   output wire        irq
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   localparam ST_TEST = 1'b0;
   localparam ST_DONE = 1'b1;
   localparam integer MINPW_LOAD = `PFT_MINPW_CYC - 1;

   reg  [15:0]          mode_r;
   reg  [7:0]           chan_cfg_r;
   reg  [7:0]           phase_cfg_r;
   reg  [31:0]          slope_r;
   reg  [31:0]          zero_r;
   reg  [31:0]          temp_r;
   reg  [1:0]           ovp_r;
   reg  [1:0]           vout_ov_r;
   reg  [1:0]           vout_uv_r;
   reg  [1:0]           fault_d_r;
   reg  [`PFT_INT_W-1:0] int_stat_r;
   reg  [`PFT_INT_W-1:0] int_mask_r;
   reg                  st_r;
   reg  [12:0]          st_cnt_r;
   reg                  open_r;
   reg  [1:0]           pend_r;
   reg  [23:0]          code_r;
   reg                  dv_busy_r;
   reg                  dv_ch_r;
   reg  [5:0]           dv_cnt_r;
   reg  [39:0]          dv_rem_r;
   reg  [39:0]          dv_quo_r;
   reg  [39:0]          dv_den_r;
   reg                  dv_neg_r;
   reg  [31:0]          rd_val;
   reg                  rd_hit;
   wire [1:0]           uv_hold;
   integer              dv_i;

   wire wr_acc    = psel & penable & pwrite;
   wire rd_setup  = psel & ~penable & ~pwrite;
   wire rd_acc    = psel & penable & ~pwrite;
   wire full_rst  = wr_acc & (paddr == `PFT_A_CTRL) & pwdata[`PFT_B_FULL_RESET];
   wire drv_mon   = chan_cfg_r[`PFT_B_DRVMON];

   assign pready = 1'b1;
   assign irq    = |(int_stat_r & int_mask_r);

   // ---------------------------------------------------------------
   // Fault conditions
   // ---------------------------------------------------------------
   // The drive monitor replaces both stage UV sources; channel 1's own UV is dropped.
   wire [1:0] stage_uv;
   assign stage_uv[0] = drv_mon ? drive_supply_uv_input
                                : (mode_r[`PFT_B_UV_EN] & stage_uv0);
   assign stage_uv[1] = drv_mon ? drive_supply_uv_input
                                : (mode_r[8+`PFT_B_UV_EN] & second_temp_fault_sense_input);

   // Stage UV counts as an overvoltage only for a channel set to run.
   wire [1:0] ov_cond = out_ov | stage_fault | (stage_uv & run_req);
   wire [1:0] uv_trig = out_uv & out_enable & ~uv_hold;
   wire       test_end = (st_r == ST_TEST) && (st_cnt_r == `PFT_SENSE_CYC - 1);
   wire [1:0] fault_rise = stage_fault & ~fault_d_r;

   wire [`PFT_INT_W-1:0] ev = {test_end & (|remote_sense_positive_open),
                               pend_upd(1'b1), fault_rise[1], uv_trig[1], ov_cond[1] & ~ovp_r[1],
                               pend_upd(1'b0), fault_rise[0], uv_trig[0], ov_cond[0] & ~ovp_r[0]};

   function pend_upd;
      input ch;
      begin
         pend_upd = dv_busy_r && (dv_cnt_r == `PFT_DIV_STEPS) && (dv_ch_r == ch);
      end
   endfunction

   // ---------------------------------------------------------------
   // Remote sense open test
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!nrst) begin
         st_r     <= ST_TEST;
         st_cnt_r <= 13'h0000;
         open_r   <= 1'b0;
      end else if (full_rst) begin
         st_r     <= ST_TEST;
         st_cnt_r <= 13'h0000;
      end else begin
         case (st_r)
            ST_TEST: begin
               st_cnt_r <= st_cnt_r + 13'h0001;
               if (test_end) begin
                  st_r   <= ST_DONE;
                  open_r <= |remote_sense_positive_open;
               end
            end
            default: st_r <= ST_DONE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Per-channel output control: UV retry and minimum pulse
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_ch
         reg [24:0] uv_cnt_r;
         reg        uv_hold_r;
         reg        pwm_d_r;
         reg [1:0]  pw_cnt_r;
         wire       minpw = mode_r[g*8+`PFT_B_MINPW];
         wire       drive = pwm_in[g] | (pw_cnt_r != 2'b00);
         assign uv_hold[g] = uv_hold_r;

         always @(posedge core_clk) begin
            if (!nrst) begin
               uv_cnt_r   <= 25'h0000000;
               uv_hold_r  <= 1'b0;
               pwm_d_r    <= 1'b0;
               pw_cnt_r   <= 2'b00;
               pwm_out[g] <= 1'b0;
            end else begin
               // Output UV shuts the channel off and retries after the delay.
               if (uv_trig[g]) begin
                  uv_hold_r <= 1'b1;
                  uv_cnt_r  <= UV_RETRY_CYC;
               end else if (uv_cnt_r != 25'h0000000) begin
                  uv_cnt_r <= uv_cnt_r - 25'h0000001;
               end else begin
                  uv_hold_r <= 1'b0;
               end
               pwm_d_r <= pwm_in[g];
               if (pwm_in[g] & ~pwm_d_r & minpw)
                  pw_cnt_r <= MINPW_LOAD[1:0];
               else if (pw_cnt_r != 2'b00)
                  pw_cnt_r <= pw_cnt_r - 2'b01;
               pwm_out[g] <= out_enable[g] & (minpw ? drive : pwm_in[g]);
            end
         end
      end
   endgenerate

   always @(posedge core_clk) begin
      if (!nrst) begin
         out_enable      <= 2'b00;
         phase_pair_mode <= 1'b0;
      end else begin
         // Outputs stay off during the sense test and after an open line.
         out_enable <= run_req & ~ovp_r & ~ov_cond & ~uv_hold & ~uv_trig &
                       {2{(st_r == ST_DONE) & ~open_r}};
         phase_pair_mode <= phase_cfg_r[`PFT_B_PHASE0] & ~drv_mon;
      end
   end

   // ---------------------------------------------------------------
   // Temperature conversion
   // ---------------------------------------------------------------
   // Linear-11 word to signed fixed point with eight fraction bits.
   function [39:0] to_fx;
      input [15:0] w;
      reg signed [39:0] m;
      reg signed [6:0]  sh;
      begin
         m  = {{29{w[10]}}, w[10:0]};
         sh = $signed({{2{w[15]}}, w[15:11]}) + 7'sd8;
         if (sh[6])
            to_fx = m >>> (7'sd0 - sh);
         else
            to_fx = m <<< sh;
      end
   endfunction

   wire        sel     = ~pend_r[0];
   wire [39:0] v_fx    = {16'h0000, (sel ? code_r[23:12] : code_r[11:0]), 12'h000} >>
                         (12 - `PFT_FX_FRAC);
   wire [39:0] off_fx  = to_fx(sel ? zero_r[31:16] : zero_r[15:0]);
   wire [39:0] slp_fx  = to_fx(sel ? slope_r[31:16] : slope_r[15:0]);
   wire [39:0] diff    = v_fx - off_fx;
   wire [39:0] dmag    = diff[39] ? (40'h0 - diff) : diff;
   wire [39:0] smag    = slp_fx[39] ? (40'h0 - slp_fx) : slp_fx;
   wire [79:0] dv_sh   = {dv_rem_r[38:0], dv_quo_r, 1'b0};
   wire        dv_ge   = dv_sh[79:40] >= dv_den_r;
   wire [10:0] q_mag   = (|dv_quo_r[39:10]) ? `PFT_MANT_MAX : {1'b0, dv_quo_r[9:0]};
   wire [10:0] q_mant  = dv_neg_r ? (11'h000 - q_mag) : q_mag;

   always @(posedge core_clk) begin
      if (!nrst) begin
         pend_r    <= 2'b00;
         code_r    <= 24'h000000;
         dv_busy_r <= 1'b0;
         dv_ch_r   <= 1'b0;
         dv_cnt_r  <= 6'h00;
         dv_rem_r  <= 40'h0;
         dv_quo_r  <= 40'h0;
         dv_den_r  <= 40'h0;
         dv_neg_r  <= 1'b0;
         temp_r    <= 32'h00000000;
      end else begin
         if (!dv_busy_r && (pend_r != 2'b00)) begin
            dv_busy_r <= 1'b1;
            dv_ch_r   <= sel;
            dv_cnt_r  <= 6'h00;
            dv_rem_r  <= 40'h0;
            dv_quo_r  <= {dmag[37:0], 2'b00};     // Quarter-degree resolution.
            dv_den_r  <= smag;
            dv_neg_r  <= diff[39] ^ slp_fx[39];
         end else if (dv_busy_r && (dv_cnt_r != `PFT_DIV_STEPS)) begin
            dv_cnt_r <= dv_cnt_r + 6'h01;
            dv_rem_r <= dv_ge ? (dv_sh[79:40] - dv_den_r) : dv_sh[79:40];
            dv_quo_r <= {dv_sh[39:1], dv_ge};
         end else if (dv_busy_r) begin
            dv_busy_r <= 1'b0;
            temp_r[dv_ch_r*16 +: 16] <= {`PFT_TEMP_EXP, q_mant};
         end
         // A new sample on the channel just taken keeps its pending bit.
         for (dv_i = 0; dv_i < 2; dv_i = dv_i + 1) begin
            if (sense_valid[dv_i] & ~stage_fault[dv_i]) begin
               pend_r[dv_i]              <= 1'b1;
               code_r[dv_i*12 +: 12]     <= temp_fault_sense_input[dv_i*12 +: 12];
            end else if (!dv_busy_r && (pend_r != 2'b00) && (sel == dv_i[0])) begin
               pend_r[dv_i] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Status, faults and interrupts
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!nrst) begin
         ovp_r      <= 2'b00;
         vout_ov_r  <= 2'b00;
         vout_uv_r  <= 2'b00;
         fault_d_r  <= 2'b00;
         int_stat_r <= {`PFT_INT_W{1'b0}};
      end else begin
         fault_d_r <= stage_fault;
         if (full_rst) begin
            ovp_r     <= 2'b00;
            vout_ov_r <= 2'b00;
            vout_uv_r <= 2'b00;
         end else begin
            ovp_r     <= ovp_r | ov_cond;
            vout_ov_r <= vout_ov_r | ov_cond | {2{test_end & (|remote_sense_positive_open)}};
            vout_uv_r <= vout_uv_r | uv_trig | {2{test_end & (|remote_sense_positive_open)}};
         end
         // Only the bits handed out by this read are cleared; new events win.
         if (rd_acc && (paddr == `PFT_A_INT_STAT))
            int_stat_r <= (int_stat_r & ~prdata[`PFT_INT_W-1:0]) | ev;
         else
            int_stat_r <= int_stat_r | ev;
      end
   end

   // ---------------------------------------------------------------
   // APB register file
   // ---------------------------------------------------------------
   always @* begin
      rd_hit = 1'b1;
      rd_val = 32'h00000000;
      case (paddr)
         `PFT_A_CTRL:      rd_val = 32'h00000000;
         `PFT_A_MODE0:     rd_val[7:0] = mode_r[7:0];
         `PFT_A_MODE1:     rd_val[7:0] = mode_r[15:8];
         `PFT_A_CHAN_CFG:  rd_val[7:0] = chan_cfg_r;
         `PFT_A_PHASE_CFG: rd_val[7:0] = phase_cfg_r;
         `PFT_A_SLOPE0:    rd_val[15:0] = slope_r[15:0];
         `PFT_A_SLOPE1:    rd_val[15:0] = slope_r[31:16];
         `PFT_A_ZERO0:     rd_val[15:0] = zero_r[15:0];
         `PFT_A_ZERO1:     rd_val[15:0] = zero_r[31:16];
         `PFT_A_TEMP0:     rd_val[15:0] = temp_r[15:0];
         `PFT_A_TEMP1:     rd_val[15:0] = temp_r[31:16];
         `PFT_A_STAT0: begin
            rd_val[`PFT_B_VOUT_OV]    = vout_ov_r[0];
            rd_val[`PFT_B_VOUT_UV]    = vout_uv_r[0];
            rd_val[`PFT_B_IOUT_STAGE] = stage_fault[0];
         end
         `PFT_A_STAT1: begin
            rd_val[`PFT_B_VOUT_OV]    = vout_ov_r[1];
            rd_val[`PFT_B_VOUT_UV]    = vout_uv_r[1];
            rd_val[`PFT_B_IOUT_STAGE] = stage_fault[1];
         end
         `PFT_A_PADS: begin
            rd_val[`PFT_B_RDY0] = ~stage_uv[0];
            rd_val[`PFT_B_RDY1] = ~stage_uv[1];
         end
         `PFT_A_INT_STAT:  rd_val[`PFT_INT_W-1:0] = int_stat_r;
         `PFT_A_INT_MASK:  rd_val[`PFT_INT_W-1:0] = int_mask_r;
         default:          rd_hit = 1'b0;
      endcase
   end

   always @(posedge core_clk) begin
      if (!nrst) begin
         prdata      <= 32'h00000000;
         pslverr     <= 1'b0;
         mode_r      <= {`PFT_MODE_RST, `PFT_MODE_RST};
         chan_cfg_r  <= `PFT_CHAN_CFG_RST;
         phase_cfg_r <= `PFT_PHASE_CFG_RST;
         slope_r     <= {`PFT_SLOPE_RST, `PFT_SLOPE_RST};
         zero_r      <= {`PFT_ZERO_RST, `PFT_ZERO_RST};
         int_mask_r  <= {`PFT_INT_W{1'b0}};
      end else begin
         if (psel & ~penable) begin
            prdata  <= rd_setup ? rd_val : 32'h00000000;
            pslverr <= ~rd_hit;
         end
         if (wr_acc) begin
            case (paddr)
               `PFT_A_MODE0:     mode_r[7:0]    <= pwdata[7:0];
               `PFT_A_MODE1:     mode_r[15:8]   <= pwdata[7:0];
               `PFT_A_CHAN_CFG:  chan_cfg_r     <= pwdata[7:0];
               `PFT_A_PHASE_CFG: phase_cfg_r    <= pwdata[7:0];
               `PFT_A_SLOPE0:    slope_r[15:0]  <= pwdata[15:0];
               `PFT_A_SLOPE1:    slope_r[31:16] <= pwdata[15:0];
               `PFT_A_ZERO0:     zero_r[15:0]   <= pwdata[15:0];
               `PFT_A_ZERO1:     zero_r[31:16]  <= pwdata[15:0];
               `PFT_A_INT_MASK:  int_mask_r     <= pwdata[`PFT_INT_W-1:0];
               default:          int_mask_r     <= int_mask_r;
            endcase
         end
      end
   end

endmodule // pft_top

// ---- sim/pft_asserts.sv ----
// Port checks for the power stage telemetry block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module pft_asserts #(
   parameter [24:0] UV_RETRY_CYC = 25'd20
) (
   // Clock and reset
   input wire       core_clk,
   input wire       nrst,
   // Watched signals
   input wire [1:0] stage_fault,
   input wire [1:0] run_req,
   input wire [1:0] out_ov,
   input wire [1:0] out_enable,
   input wire [1:0] pwm_out,
   input wire       irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // ----------------------------------------------------------------
   // Output control
   // ----------------------------------------------------------------
   property p_rst_hold; $rose(nrst) |-> (out_enable == 2'b00) [*8]; endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("output on in sense test");
   property p_flt0; stage_fault[0] && run_req[0] && out_enable[0] |=> !out_enable[0] [*8]; endproperty
   a_flt0: assert property (p_flt0) else $error("stage fault ch0 kept output");
   property p_flt1; stage_fault[1] && run_req[1] && out_enable[1] |=> !out_enable[1] [*8]; endproperty
   a_flt1: assert property (p_flt1) else $error("stage fault ch1 kept output");
   property p_ov0; out_ov[0] && out_enable[0] |=> !out_enable[0]; endproperty
   a_ov0: assert property (p_ov0) else $error("overvoltage ch0 kept output");
   property p_ov1; out_ov[1] && out_enable[1] |=> !out_enable[1]; endproperty
   a_ov1: assert property (p_ov1) else $error("overvoltage ch1 kept output");
   property p_en0; $rose(out_enable[0]) |-> $past(run_req[0]) && !$past(out_ov[0]); endproperty
   a_en0: assert property (p_en0) else $error("ch0 enabled without cause");
   property p_en1; $rose(out_enable[1]) |-> $past(run_req[1]) && !$past(out_ov[1]); endproperty
   a_en1: assert property (p_en1) else $error("ch1 enabled without cause");
   property p_minpw1; $rose(pwm_out[1]) |=> pwm_out[1]; endproperty
   a_minpw1: assert property (p_minpw1) else $error("ch1 pulse too short");

   c_trip: cover property (stage_fault[1] && out_enable[1]);
   c_irq: cover property ($rose(irq));
   c_ov: cover property (out_ov[0] && out_enable[0]);
endmodule // pft_asserts

bind pft_top pft_asserts #(.UV_RETRY_CYC(UV_RETRY_CYC)) u_chk (
   .core_clk(core_clk), .nrst(nrst), .stage_fault(stage_fault), .run_req(run_req),
   .out_ov(out_ov), .out_enable(out_enable), .pwm_out(pwm_out), .irq(irq));

// ---- sim/pft_stage_model.sv ----
// Behavioural model of the power stages on the shared sense lines.
// Assumes the bench sets the sensed voltage and the fault and UV requests.
`timescale 1ns/1ps
module pft_stage_model #(
   parameter int PERIOD = 64
) (
   // Clock
   input  wire         core_clk,
   // Requests from the bench
   input  wire  [11:0] temp_mv,
   input  wire  [1:0]  fault_req,
   input  wire  [1:0]  uv_req,
   // Lines towards the block
   output logic [23:0] sense_code = 24'h0,
   output logic [1:0]  sense_valid = 2'h0,
   output logic [1:0]  stage_fault = 2'h0,
   output logic        uv0 = 1'b0,
   output logic        uv1 = 1'b0
);
   int n = 0;

   // A faulted stage pulls its line hard, so its code reads full scale.
   always @(posedge core_clk) begin
      n <= (n == PERIOD - 1) ? 0 : n + 1;
      sense_valid <= {2{n == 0}};
      sense_code <= {fault_req[1] ? 12'hfff : temp_mv, fault_req[0] ? 12'hfff : temp_mv};
      stage_fault <= fault_req;
      uv0 <= uv_req[0];
      uv1 <= uv_req[1];
   end
endmodule // pft_stage_model

// ---- sim/pft_top_test.sv ----
// Self-checking bench for the power stage telemetry block.
// Assumes the stage model and the port checker are compiled alongside.
`timescale 1ns/1ps
`include "pft_regs.vh"
module pft_top_test;
   logic        core_clk, nrst, psel, penable, pwrite, drv_uv, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, q;
   logic [11:0] temp_mv;
   logic [1:0]  flt_req, uv_req, ov, uv, open, run, pwm_in;
   wire  [31:0] prdata;
   wire  [23:0] code;
   wire  [1:0]  valid, sfault, pwm_out, out_en;
   wire         pready, pslverr, ppm, irq, uv0, uv1;
   int          num_errors = 0;
   int          checks_done = 0;

   pft_top #(.UV_RETRY_CYC(25'd20)) DUT (
      .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .temp_fault_sense_input(code),
      .sense_valid(valid), .stage_fault(sfault), .stage_uv0(uv0),
      .second_temp_fault_sense_input(uv1), .drive_supply_uv_input(drv_uv),
      .out_ov(ov), .out_uv(uv), .remote_sense_positive_open(open), .run_req(run),
      .pwm_in(pwm_in), .pwm_out(pwm_out), .out_enable(out_en),
      .phase_pair_mode(ppm), .irq(irq));
   pft_stage_model MDL (
      .core_clk(core_clk), .temp_mv(temp_mv), .fault_req(flt_req), .uv_req(uv_req),
      .sense_code(code), .sense_valid(valid), .stage_fault(sfault), .uv0(uv0), .uv1(uv1));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Setup edge, then access edges until pready is seen high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task wait_en;
      int k;
      k = 0;
      while (out_en !== 2'b11 && k < 700) begin
         cyc(1);
         k++;
      end
      chk({30'h0, out_en}, 32'h3);
   endtask
   task pulse(input logic [31:0] exp);
      logic [31:0] n;
      n = 0;
      @(posedge core_clk) pwm_in <= 2'b11;
      @(posedge core_clk) pwm_in <= 2'b00;
      repeat (6) begin
         #1;
         n = n + pwm_out[0] + pwm_out[1];
         @(posedge core_clk);
      end
      chk(n, exp);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_regs;
      rd(`PFT_A_SLOPE1, 32'hd200);
      rd(`PFT_A_ZERO0, 32'h0258);
      rd(`PFT_A_PADS, 32'hc000);
      chk({31'h0, ppm}, 32'h1);
      apb(1'b0, 8'h4c, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("test regs done");
   endtask
   task t_uv;
      @(posedge core_clk) uv_req <= 2'b11;
      rd(`PFT_A_PADS, 32'hc000);
      apb(1'b1, `PFT_A_MODE0, 32'h3);
      rd(`PFT_A_PADS, 32'h8000);
      apb(1'b1, `PFT_A_MODE1, 32'h3);
      rd(`PFT_A_PADS, 32'h0000);
      apb(1'b1, `PFT_A_CHAN_CFG, 32'h3d);
      rd(`PFT_A_PADS, 32'hc000);
      chk({31'h0, ppm}, 32'h0);
      @(posedge core_clk) drv_uv <= 1'b1;
      rd(`PFT_A_PADS, 32'h0000);
      @(posedge core_clk) drv_uv <= 1'b0;
      uv_req <= 2'b00;
      apb(1'b1, `PFT_A_CHAN_CFG, 32'h1d);
      rd(`PFT_A_PADS, 32'hc000);
      $display("test uv done");
   endtask
   task t_temp;
      rd(`PFT_A_TEMP0, 32'hf0c8);
      apb(1'b1, `PFT_A_ZERO0, 32'h190);
      apb(1'b1, `PFT_A_SLOPE1, 32'hd100);
      cyc(200);
      rd(`PFT_A_TEMP0, 32'hf12c);
      rd(`PFT_A_TEMP1, 32'hf190);
      $display("test temp done");
   endtask
   task t_fault;
      pulse(32'h4);
      apb(1'b1, `PFT_A_MODE0, 32'h1);
      pulse(32'h3);
      apb(1'b1, `PFT_A_INT_MASK, 32'h0);
      @(posedge core_clk) flt_req <= 2'b10;
      cyc(200);
      chk({30'h0, out_en}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rd(`PFT_A_TEMP1, 32'hf190);
      apb(1'b1, `PFT_A_INT_MASK, 32'h40);
      cyc(2);
      chk({31'h0, irq}, 32'h1);
      rd(`PFT_A_STAT1, 32'h0880);
      @(posedge core_clk) flt_req <= 2'b00;
      rd(`PFT_A_STAT1, 32'h0080);
      chk({30'h0, out_en}, 32'h1);
      apb(1'b0, `PFT_A_INT_STAT, 32'h0);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      @(posedge core_clk) ov <= 2'b01;
      cyc(3);
      chk({30'h0, out_en}, 32'h0);
      @(posedge core_clk) ov <= 2'b00;
      $display("test fault done");
   endtask
   task t_open;
      @(posedge core_clk) open <= 2'b10;
      apb(1'b1, `PFT_A_CTRL, 32'h1);
      cyc(600);
      chk({30'h0, out_en}, 32'h0);
      apb(1'b0, `PFT_A_STAT1, 32'h0);
      chk(q & 32'h90, 32'h90);
      @(posedge core_clk) open <= 2'b00;
      cyc(600);
      chk({30'h0, out_en}, 32'h0);
      apb(1'b1, `PFT_A_CTRL, 32'h1);
      wait_en();
      @(posedge core_clk) uv <= 2'b01;
      @(posedge core_clk) uv <= 2'b00;
      cyc(2);
      chk({30'h0, out_en}, 32'h2);
      wait_en();
      rd(`PFT_A_STAT0, 32'h0010);
      @(posedge core_clk) uv_req <= 2'b10;
      cyc(4);
      chk({30'h0, out_en}, 32'h1);
      $display("test open done");
   endtask

   task results;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      #(20 * 40000);
      num_errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      results();
   end
   initial begin
      {nrst, psel, penable, pwrite, drv_uv, paddr, pwdata} = '0;
      {flt_req, uv_req, ov, uv, open, run, pwm_in} = '0;
      temp_mv = 12'd1000;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      t_regs();
      t_uv();
      @(posedge core_clk) run <= 2'b11;
      wait_en();
      t_temp();
      t_fault();
      t_open();
      results();
   end
endmodule // pft_top_test
